/* verilog/ioxp_pkg.sv */
package ioxp_pkg;
  // ---------------------------------------------------------------
  // Register indices (command byte values)
  // ---------------------------------------------------------------
  localparam logic [2:0] IOXP_REG_IN0   = 3'h0;
  localparam logic [2:0] IOXP_REG_IN1   = 3'h1;
  localparam logic [2:0] IOXP_REG_OUT0  = 3'h2;
  localparam logic [2:0] IOXP_REG_OUT1  = 3'h3;
  localparam logic [2:0] IOXP_REG_POL0  = 3'h4;
  localparam logic [2:0] IOXP_REG_POL1  = 3'h5;
  localparam logic [2:0] IOXP_REG_CFG0  = 3'h6;
  localparam logic [2:0] IOXP_REG_CFG1  = 3'h7;
  // ---------------------------------------------------------------
  // Reset values and address
  // ---------------------------------------------------------------
  localparam logic [7:0] IOXP_OUT_RST   = 8'hff;
  localparam logic [7:0] IOXP_POL_RST   = 8'h00;
  localparam logic [7:0] IOXP_CFG_RST   = 8'hff;
  localparam logic [5:0] IOXP_ADDR_HI   = 6'h10;
  localparam int         IOXP_CMD_BITS  = 3;
  // ---------------------------------------------------------------
  // Host APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] IOXP_A_CTRL    = 8'h00;
  localparam logic [7:0] IOXP_A_STAT    = 8'h04;
  localparam logic [7:0] IOXP_A_RDATA   = 8'h08;
  localparam int         IOXP_C_GO      = 0;
  localparam int         IOXP_C_RD      = 1;
  localparam int         IOXP_C_NOCMD   = 2;
  localparam int         IOXP_C_STRAP   = 3;
  localparam int         IOXP_C_CMD     = 8;
  localparam int         IOXP_C_WDATA   = 16;
  localparam int         IOXP_C_CNT     = 24;
  localparam int         IOXP_S_BUSY    = 0;
  localparam int         IOXP_S_NACK    = 1;
  localparam int         IOXP_S_INT     = 2;
  // Bit phase length in mclk cycles; SCL half period is two phases
  localparam int         IOXP_HALF_CYC  = 4;
endpackage : ioxp_pkg

/* verilog/ioxp_link_if.sv */
`timescale 1ns/1ns
interface ioxp_link_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic int_b;
  // Open-drain wired-and of both ends, pulled up
  wire  sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
  modport dev  (input scl, input sda, output sda_s_out, output sda_s_oe,
                output int_b);
  modport host (output scl, input sda, output sda_m_out, output sda_m_oe,
                input int_b);
endinterface : ioxp_link_if

/* verilog/ioxp_edge_det.sv */
`timescale 1ns/1ns
module ioxp_edge_det #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_b_in,
  // Sampled signals
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  // Bus events
  output logic              scl_rise_out,
  output logic              scl_fall_out,
  output logic              start_out,
  output logic              stop_out
);
  logic scl_q;
  logic sda_q;
  // ---------------------------------------------------------------
  // Previous-value registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end
  // Conditions: SDA moves while SCL high
  assign scl_rise_out = scl_in && !scl_q;
  assign scl_fall_out = !scl_in && scl_q;
  assign start_out    = scl_in && scl_q && sda_q && !sda_in;
  assign stop_out     = scl_in && scl_q && !sda_q && sda_in;
endmodule : ioxp_edge_det

/* verilog/ioxp_dev.sv */
`timescale 1ns/1ns
// Functional notes
// - Address 0x20 or 0x21 from strap
// - Last address bit: 1 read, 0 write
// - First written byte loads pointer
// - Commands 0..7 select the eight registers
// - Reads start at pointer until rewritten
// - Input registers show pins, ignore writes
// - Output latch drives output pins, reads latch
// - Polarity bit inverts input readback
// - Configuration 1 input, 0 output
// - First data byte goes to pointed register
// - Write pointer toggles within pair
// - Command write, restart, then read
// - Restart keeps current register as pointer
// - Read pointer toggles within pair
// - Transmit data loaded at ack rising edge
// - Master NACKs last read byte
// - Stop anytime; last acked data valid
// - Read without command returns pointed port
// - Acknowledge address and every received byte
// - Reset restores register defaults
// - Input edge asserts interrupt; clears on cases
module ioxp_dev
  import ioxp_pkg::*;
#(
  parameter int PINS = 16
) (
  // Clock and reset
  input  wire logic            mclk_in,
  input  wire logic            rst_b_in,
  // Address strap
  input  wire logic            addr_strap_in,
  // Bus link
  ioxp_link_if.dev             link,
  // Expander pins
  input  wire logic [7:0]      expander_pin_low_port_in,
  input  wire logic [7:0]      expander_pin_high_port_in,
  output logic [7:0]           expander_pin_low_port_out,
  output logic [7:0]           expander_pin_high_port_out,
  output logic [7:0]           expander_pin_low_port_oe_out,
  output logic [7:0]           expander_pin_high_port_oe_out
);
  if (PINS != 16) begin : g_chk
    $error("ioxp_dev serves sixteen pins only");
  end

  typedef enum logic [2:0] {
    IOXP_IDLE = 3'b000,
    IOXP_ADDR = 3'b001,
    IOXP_AACK = 3'b010,
    IOXP_RXB  = 3'b011,
    IOXP_WACK = 3'b100,
    IOXP_TXB  = 3'b101,
    IOXP_RACK = 3'b110
  } ioxp_state_e;

  ioxp_state_e state;
  logic [7:0]  out0, out1, pol0, pol1, cfg0, cfg1;
  logic [2:0]  ptr;
  logic        cmd_seen;
  logic [7:0]  shift;
  logic [3:0]  bitn;
  logic        ack_drv;
  logic        rw;         // Direction bit of the last matched address
  logic        int_pend;
  logic [15:0] in_ref;
  wire         scl_rise, scl_fall, start_ev, stop_ev;
  wire  [15:0] pins_in = {expander_pin_high_port_in,
                          expander_pin_low_port_in};
  wire  [15:0] cfg     = {cfg1, cfg0};

  ioxp_edge_det #(.W(16)) u_edge (
    .mclk_in      (mclk_in),
    .rst_b_in     (rst_b_in),
    .scl_in       (link.scl),
    .sda_in       (link.sda),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_ev),
    .stop_out     (stop_ev)
  );

  // ---------------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_reg(input logic [2:0] idx);
    unique case (idx)
      IOXP_REG_IN0:  rd_reg = expander_pin_low_port_in ^ pol0;
      IOXP_REG_IN1:  rd_reg = expander_pin_high_port_in ^ pol1;
      IOXP_REG_OUT0: rd_reg = out0;
      IOXP_REG_OUT1: rd_reg = out1;
      IOXP_REG_POL0: rd_reg = pol0;
      IOXP_REG_POL1: rd_reg = pol1;
      IOXP_REG_CFG0: rd_reg = cfg0;
      IOXP_REG_CFG1: rd_reg = cfg1;
    endcase
  endfunction : rd_reg

  // Address match: fixed upper six bits, strap in bit 0
  wire        addr_hit  = shift[7:1] == {IOXP_ADDR_HI, addr_strap_in};
  wire [7:0]  rx_byte   = {shift[6:0], link.sda};
  wire [2:0]  ptr_pair  = {ptr[2:1], ~ptr[0]};
  wire        in_sel_rd = (ptr == IOXP_REG_IN0) || (ptr == IOXP_REG_IN1);
  wire        rd_clear  = scl_rise && state == IOXP_RACK && in_sel_rd;
  wire [15:0] in_chg    = (pins_in ^ in_ref) & cfg;

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= IOXP_IDLE;
      ptr      <= IOXP_REG_IN0;
      cmd_seen <= 1'b0;
      shift    <= 8'h00;
      bitn     <= 4'h0;
      ack_drv  <= 1'b0;
      rw       <= 1'b0;
      out0     <= IOXP_OUT_RST;
      out1     <= IOXP_OUT_RST;
      pol0     <= IOXP_POL_RST;
      pol1     <= IOXP_POL_RST;
      cfg0     <= IOXP_CFG_RST;
      cfg1     <= IOXP_CFG_RST;
    end else if (stop_ev) begin
      state   <= IOXP_IDLE;
      ack_drv <= 1'b0;
    end else if (start_ev) begin                         // ptr kept
      state   <= IOXP_ADDR;
      bitn    <= 4'h0;
      ack_drv <= 1'b0;
    end else begin
      unique case (state)
        IOXP_IDLE: ;
        IOXP_ADDR, IOXP_RXB: begin
          if (scl_rise) begin
            shift <= rx_byte;
            bitn  <= bitn + 4'h1;
          end
          if (scl_fall && bitn == 4'h8) begin
            bitn <= 4'h0;
            if (state == IOXP_ADDR && !addr_hit) begin
              state <= IOXP_IDLE;
            end else begin
              ack_drv <= 1'b1;
              state   <= (state == IOXP_ADDR) ? IOXP_AACK : IOXP_WACK;
            end
          end
        end
        IOXP_AACK: begin
          // Keep the direction bit: a read reloads shift at this rise
          if (scl_rise) begin
            rw <= shift[0];
            if (shift[0]) begin
              shift <= rd_reg(ptr);
            end
          end
          if (scl_fall) begin
            ack_drv  <= 1'b0;
            cmd_seen <= 1'b0;
            state    <= rw ? IOXP_TXB : IOXP_RXB;
          end
        end
        IOXP_WACK: begin
          if (scl_rise) begin
            if (!cmd_seen) begin
              ptr      <= shift[IOXP_CMD_BITS-1:0];
              cmd_seen <= 1'b1;
            end else begin
              unique case (ptr)
                IOXP_REG_OUT0: out0 <= shift;
                IOXP_REG_OUT1: out1 <= shift;
                IOXP_REG_POL0: pol0 <= shift;
                IOXP_REG_POL1: pol1 <= shift;
                IOXP_REG_CFG0: cfg0 <= shift;
                IOXP_REG_CFG1: cfg1 <= shift;
                default: ;                               // ignored
              endcase
              ptr <= ptr_pair;
            end
          end
          if (scl_fall) begin
            ack_drv <= 1'b0;
            state   <= IOXP_RXB;
          end
        end
        IOXP_TXB: begin
          if (scl_fall) begin
            if (bitn == 4'h7) begin
              bitn  <= 4'h0;
              state <= IOXP_RACK;
            end else begin
              shift <= {shift[6:0], 1'b0};
              bitn  <= bitn + 4'h1;
            end
          end
        end
        IOXP_RACK: begin
          if (scl_rise) begin
            if (link.sda) begin
              state <= IOXP_IDLE;
            end else begin
              ptr   <= ptr_pair;
              shift <= rd_reg(ptr_pair);
            end
          end
          if (scl_fall) state <= IOXP_TXB;
        end
        default: state <= IOXP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt: input change against reference level
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_ref   <= 16'h0000;
      int_pend <= 1'b0;
    end else begin
      if (rd_clear || stop_ev) begin
        in_ref   <= pins_in;
        int_pend <= 1'b0;
      end else begin
        int_pend <= |in_chg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin and link drivers
  // ---------------------------------------------------------------
  assign expander_pin_low_port_out     = out0;
  assign expander_pin_high_port_out    = out1;
  assign expander_pin_low_port_oe_out  = ~cfg0;
  assign expander_pin_high_port_oe_out = ~cfg1;
  assign link.sda_s_out = 1'b0;
  assign link.sda_s_oe  = ack_drv || (state == IOXP_TXB && !shift[7]);
  assign link.int_b     = !int_pend;
endmodule : ioxp_dev

/* verilog/ioxp_host.sv */
`timescale 1ns/1ns
module ioxp_host
  import ioxp_pkg::*;
#(
  parameter int HALF = IOXP_HALF_CYC
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Bus link
  ioxp_link_if.host        link
);
  if (HALF < 2) begin : g_chk
    $error("ioxp_host needs HALF of at least 2");
  end

  typedef enum logic [1:0] {
    IOXP_H_IDLE = 2'b00,
    IOXP_H_RUN  = 2'b01,
    IOXP_H_STOP = 2'b10
  } ioxp_hstate_e;

  ioxp_hstate_e hst;
  logic [31:0]  ctrl;
  logic [31:0]  rdata;
  logic         nack;
  logic [7:0]   div;
  logic [1:0]   ph;
  logic [8:0]   tx;
  logic [3:0]   bitc;
  logic [2:0]   byten;
  logic [7:0]   left;
  logic         scl_q, sda_low;

  wire acc  = psel_in && penable_in;
  wire wr   = acc && pwrite_in && paddr_in == IOXP_A_CTRL;
  wire tick = div == 8'(HALF - 1);
  wire rdm  = ctrl[IOXP_C_RD];
  // Byte sequence: 0 addr-w, 1 cmd, 2 restart addr-r, 3 data
  wire [7:0] addr_w = {IOXP_ADDR_HI, ctrl[IOXP_C_STRAP], 1'b0};
  wire [7:0] addr_r = {IOXP_ADDR_HI, ctrl[IOXP_C_STRAP], 1'b1};

  assign pready_out  = 1'b1;
  assign pslverr_out = 1'b0;
  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl       <= 32'h0000_0000;
      prdata_out <= 32'h0000_0000;
    end else begin
      if (wr && hst == IOXP_H_IDLE) ctrl <= pwdata_in;
      else if (hst != IOXP_H_IDLE) ctrl[IOXP_C_GO] <= 1'b0;
      if (psel_in && !penable_in) begin
        unique case (paddr_in)
          IOXP_A_CTRL:  prdata_out <= ctrl;
          IOXP_A_STAT:  prdata_out <= {29'h0, !link.int_b, nack,
                                       hst != IOXP_H_IDLE};
          IOXP_A_RDATA: prdata_out <= rdata;
          default:      prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit engine: four phases per bit
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hst <= IOXP_H_IDLE; div <= 8'h00; ph <= 2'h0; tx <= 9'h1ff;
      bitc <= 4'h0; byten <= 3'h0; left <= 8'h00; scl_q <= 1'b1;
      sda_low <= 1'b0; rdata <= 32'h0; nack <= 1'b0;
    end else begin
      div <= tick ? 8'h00 : div + 8'h01;
      unique case (hst)
        IOXP_H_IDLE: begin
          scl_q <= 1'b1; sda_low <= 1'b0;
          if (ctrl[IOXP_C_GO]) begin
            hst <= IOXP_H_RUN; ph <= 2'h0; bitc <= 4'h0; nack <= 1'b0;
            left <= ctrl[IOXP_C_CNT +: 8];
            byten <= ctrl[IOXP_C_NOCMD] ? 3'h2 : 3'h0;
            tx <= {ctrl[IOXP_C_NOCMD] ? addr_r : addr_w, 1'b1};
            sda_low <= 1'b1;                     // Start
          end
        end
        IOXP_H_RUN: if (tick) begin
          ph <= ph + 2'h1;
          unique case (ph)
            2'h0: begin scl_q <= 1'b0; end
            2'h1: sda_low <= !tx[8];
            2'h2: scl_q <= 1'b1;
            2'h3: begin
              tx <= {tx[7:0], 1'b1};
              bitc <= bitc + 4'h1;
              if (byten == 3'h3 && rdm && bitc < 4'h8)
                rdata <= {rdata[30:0], link.sda};
              if (bitc == 4'h8) begin
                bitc <= 4'h0;
                if (byten != 3'h3 || !rdm) nack <= nack | link.sda;
                if (byten == 3'h0) begin
                  byten <= 3'h1; tx <= {ctrl[IOXP_C_CMD +: 8], 1'b1};
                end else if (byten == 3'h1 && rdm) begin
                  byten <= 3'h4;                 // Restart next
                end else if (left == 8'h00 || (byten==3'h1 && !rdm)
                             && left == 8'h00) begin
                  hst <= IOXP_H_STOP;
                end else begin
                  byten <= 3'h3; left <= left - 8'h01;
                  tx <= rdm ? {8'hff, left == 8'h01}
                            : {ctrl[IOXP_C_WDATA +: 8], 1'b1};
                end
              end
            end
          endcase
          if (ph == 2'h1 && byten == 3'h4) begin // Restart
            sda_low <= 1'b0;
          end
          if (ph == 2'h3 && byten == 3'h4) begin
            sda_low <= 1'b1; byten <= 3'h2;
            bitc <= 4'h0;                        // Restart bit not counted
            tx <= {addr_r, 1'b1};
          end
        end
        IOXP_H_STOP: if (tick) begin
          ph <= ph + 2'h1;
          unique case (ph)
            2'h0: scl_q <= 1'b0;
            2'h1: sda_low <= 1'b1;
            2'h2: scl_q <= 1'b1;
            2'h3: begin sda_low <= 1'b0; hst <= IOXP_H_IDLE; end
          endcase
        end
        default: hst <= IOXP_H_IDLE;
      endcase
    end
  end

  assign link.scl       = scl_q;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe  = sda_low;
endmodule : ioxp_host

/* testbench/ioxp_link_sva.sv */
`timescale 1ns/1ns
module ioxp_link_sva
  import ioxp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  // Link signals
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_s_out,
  input  wire logic sda_s_oe,
  input  wire logic int_b
);
  // ----------------------------------------------------------------
  // Bus decoding
  // ----------------------------------------------------------------
  logic       scl_q, sda_q, first, acked, rd;
  logic [3:0] bitn;
  logic [7:0] sh;
  // Clock rise, start, stop and the ninth clock of a byte
  wire  rise   = scl && !scl_q;
  wire  start  = scl && scl_q && sda_q && !sda;
  wire  stop   = scl && scl_q && !sda_q && sda;
  wire  ack_ph = rise && (bitn == 4'h8);
  // Bit counter and address capture
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {scl_q, sda_q, first, acked, rd, bitn, sh} <= {2'h3, 15'h0};
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      if (start || stop) begin
        {bitn, first, acked} <= {4'h0, start, 1'b0};
      end else if (ack_ph) begin
        bitn  <= 4'h0;
        first <= 1'b0;
        if (first) {acked, rd} <= {!sda, sh[0]};
      end else if (rise) begin
        bitn <= bitn + 4'h1;
        sh   <= {sh[6:0], sda};
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  property p_addr_match;
    ack_ph && first && sda_s_oe |-> sh[7:2] == IOXP_ADDR_HI;
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("ack given to a foreign address");
  property p_ack_rx;
    ack_ph && !first && acked && !rd |-> sda_s_oe;
  endproperty
  a_ack_rx: assert property (p_ack_rx)
    else $error("received byte not acknowledged");
  property p_rd_release;
    ack_ph && !first && acked && rd |-> !sda_s_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("data line held in master ack slot");
  property p_quiet;
    rise && bitn != 4'h8 && (first || !rd || !acked) |-> !sda_s_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("data driven outside a read");
  property p_hold_high;
    scl && $past(scl) |-> $stable(sda_s_oe);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("data changed while clock high");
  property p_nack_free;
    ack_ph && !first && acked && rd && sda |=> !sda_s_oe [*8];
  endproperty
  a_nack_free: assert property (p_nack_free)
    else $error("line not released after nack");
  property p_stop_int;
    stop |-> ##[0:8] int_b;
  endproperty
  a_stop_int: assert property (p_stop_int)
    else $error("interrupt kept after stop");
  property p_drive_low;
    sda_s_oe |-> !sda_s_out && !sda;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("device enable does not pull data low");
  property p_rst_idle;
    !$past(rst_b_in) |-> !sda_s_oe && int_b;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("link not idle after reset");
  // Main scenarios
  c_wr_ack: cover property (ack_ph && !first && acked && !rd);
  c_rd_nack: cover property (ack_ph && !first && acked && rd && sda);
  c_foreign: cover property (ack_ph && first && !sda_s_oe);
  c_int: cover property (!int_b);
endmodule : ioxp_link_sva

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb_top
  import ioxp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic            mclk_in = 1'b0, rst_b_in = 1'b0, strap = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]      paddr = 8'h0;
  logic [31:0]     pwdata = 32'h0, seed = 32'h460d, rv;
  logic [15:0]     ext = 16'h0;
  wire logic [31:0] prdata;
  wire logic       pready, pslverr;
  wire logic [7:0] lo_out, hi_out, lo_oe, hi_oe;
  // Pin levels: driven pins follow the latch, others the outside
  wire logic [7:0] lo_in = (lo_oe & lo_out) | (~lo_oe & ext[7:0]);
  wire logic [7:0] hi_in = (hi_oe & hi_out) | (~hi_oe & ext[15:8]);
  logic [7:0]      mem [8];
  logic [2:0]      ptr;
  int              error_cnt = 0, n_tests = 0;
  always #4 mclk_in = ~mclk_in;
  // ----------------------------------------------------------------
  // Design ends, link and checker
  // ----------------------------------------------------------------
  ioxp_link_if link ();
  ioxp_dev ioxp_dev_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .addr_strap_in(strap), .link(link),
    .expander_pin_low_port_in(lo_in), .expander_pin_high_port_in(hi_in),
    .expander_pin_low_port_out(lo_out), .expander_pin_high_port_out(hi_out),
    .expander_pin_low_port_oe_out(lo_oe),
    .expander_pin_high_port_oe_out(hi_oe));
  ioxp_host ioxp_host_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link(link));
  ioxp_link_sva ioxp_link_sva_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .scl(link.scl), .sda(link.sda), .sda_s_out(link.sda_s_out),
    .sda_s_oe(link.sda_s_oe), .int_b(link.int_b));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Input register value: pin level, optionally inverted
  function automatic logic [7:0] lvl(input logic p);
    logic [7:0] c, x;
    c = mem[6 + p];
    x = p ? ext[15:8] : ext[7:0];
    return ((~c & mem[2 + p]) | (c & x)) ^ mem[4 + p];
  endfunction : lvl
  task automatic mreset();
    {mem[2], mem[3], mem[4], mem[5]} = {IOXP_OUT_RST, IOXP_OUT_RST, 16'h0};
    {mem[6], mem[7], ptr} = {IOXP_CFG_RST, IOXP_CFG_RST, 3'h0};
  endtask : mreset
  task summarize();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge mclk_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk_in);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge mclk_in); k++; end while (pready !== 1'b1 && k < 50);
    r = prdata;
    {psel, penable} <= 2'b00;
    if (k >= 50) begin error_cnt++; summarize(); end
  endtask : apb
  // One bus transfer through the host, then model update and compare
  task automatic xfer(input logic rd, input logic nocmd, input logic s,
                      input logic [7:0] cmd, input logic [7:0] wd,
                      input logic [7:0] cnt);
    logic [31:0] r, e;
    logic [7:0]  v;
    logic        nk;
    int          k;
    apb(1'b1, IOXP_A_CTRL, {cnt, wd, cmd, 4'h0, s, nocmd, rd, 1'b1}, r);
    k = 0;
    do begin apb(1'b0, IOXP_A_STAT, 32'h0, r); k++; end
    while (r[IOXP_S_BUSY] !== 1'b0 && k < 4000);
    if (k >= 4000) begin error_cnt++; summarize(); end
    nk = (s !== strap);
    `CHK(r[IOXP_S_NACK], nk)
    if (!nk) begin
      if (!nocmd) ptr = cmd[2:0];
      e = 32'h0;
      for (int i = 0; i < cnt; i++) begin
        v = (ptr < 3'h2) ? lvl(ptr[0]) : mem[ptr];
        if (rd) e = {e[23:0], v};
        else if (ptr > 3'h1) mem[ptr] = wd;
        if (!rd || i < cnt - 1) ptr[0] = ~ptr[0];
      end
      if (rd) begin
        apb(1'b0, IOXP_A_RDATA, 32'h0, r);
        for (int i = cnt; i < 4; i++) r[8 * i +: 8] = 8'h0;
        `CHK(r, e)
      end
    end
    `CHK({hi_oe, lo_oe}, ~{mem[7], mem[6]})
    `CHK({hi_out, lo_out}, {mem[3], mem[2]})
  endtask : xfer
  // Flip outside pin levels and look at the interrupt flag
  task automatic intchk(input logic [15:0] m, input logic x);
    logic [31:0] r;
    ext <= ext ^ m;
    repeat (10) @(posedge mclk_in);
    apb(1'b0, IOXP_A_STAT, 32'h0, r);
    `CHK(r[IOXP_S_INT], x)
  endtask : intchk
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mreset();
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rv = rnd();
    ext <= rv[15:0];
    // Every register after reset
    for (int i = 0; i < 8; i++) xfer(1, 0, 0, 8'(i), 8'h0, 1);
    // Pair writes with wide commands, pair reads, reads without command
    for (int i = 0; i < 8; i++) begin
      rv = rnd();
      ext <= rv[31:16];
      xfer(0, 0, 0, 8'(i) | {rv[0], 3'h0}, rv[7:0], 8'(2 + i % 2));
      xfer(1, 0, 0, 8'(i), 8'h0, 4);
      xfer(1, 1, 0, 8'h0, 8'h0, 2);
    end
    // Both strap levels, foreign address refused
    for (int s = 0; s < 2; s++) begin
      strap <= s[0];
      rv = rnd();
      xfer(0, 0, s[0], {5'h0, IOXP_REG_OUT0}, rv[7:0], 1);
      xfer(0, 0, !s[0], {5'h0, IOXP_REG_OUT1}, rv[15:8], 1);
      xfer(1, 0, !s[0], 8'h0, 8'h0, 1);
      xfer(1, 0, s[0], {5'h0, IOXP_REG_OUT0}, 8'h0, 2);
    end
    // Interrupt from input pins only, cleared by return, read and stop
    xfer(0, 0, strap, {5'h0, IOXP_REG_CFG0}, 8'h0f, 1);
    intchk(16'h0020, 1'b0);
    intchk(16'h0002, 1'b1);
    intchk(16'h0002, 1'b0);
    intchk(16'h0004, 1'b1);
    xfer(1, 0, strap, 8'h0, 8'h0, 1);
    intchk(16'h0000, 1'b0);
    // Reset in mid-run
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    `CHK({hi_oe, lo_oe}, 16'h0)
    `CHK({hi_out, lo_out}, 16'hffff)
    rst_b_in <= 1'b1;
    mreset();
    xfer(1, 1, strap, 8'h0, 8'h0, 2);
    // Unmapped host place reads as zero
    apb(1'b0, 8'h0c, 32'h0, rv);
    `CHK(rv, 32'h0)
    `CHK(pslverr, 1'b0)
    summarize();
  end
endmodule : tb_top
